// [logic/cap2_err_regs.sv]
`timescale 1ns/100ps
module cap2_err_regs #(
	parameter bit DOWNSTREAM = 1'b0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire cap2_err_pkg::err_events_t err_events,
	input wire logic cur_deemph_level,
	output logic latency_tolerance_report_en,
	output logic [1:0] buffer_flush_fill_hint,
	output logic [3:0] target_link_speed,
	output logic enter_compliance,
	output logic autonomous_speed_change_disable,
	output logic [2:0] transmit_margin,
	output logic modified_compliance,
	output logic compliance_skip_ordered_sets,
	output logic compliance_deemphasis
);
	// -------------------------------------------------------------
	// ahb address phase capture
	// -------------------------------------------------------------
	cap2_err_pkg::ahb_addr_t addr_reg;
	logic wr_pend_reg;
	logic [31:0] dev_ctrl_reg;
	logic [31:0] link_ctrl_sticky_reg;
	logic auto_spd_reg;
	logic cur_deemph_reg;
	logic [31:0] uncorr_reg;
	logic [31:0] uncorr_next;
	logic [31:0] event_vec;
	logic [31:0] force_vec;
	logic [31:0] rd_word;
	logic wr_now;

	function automatic logic is_addr(input logic [31:0] a, input logic [11:0] ofs);
		is_addr = (a[11:2] == ofs[11:2]) && (a[31:12] == 20'h00000);
	endfunction : is_addr

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			addr_reg <= '0;
			wr_pend_reg <= 1'b0;
		end else if (hready) begin
			addr_reg <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr};
			wr_pend_reg <= hsel && htrans[1] && hwrite;
		end
	end

	assign wr_now = wr_pend_reg;

	// -------------------------------------------------------------
	// device control ext (non-sticky)
	// -------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dev_ctrl_reg <= '0;
		end else if (soft_reset) begin
			dev_ctrl_reg <= '0;
		end else if (wr_now && is_addr(addr_reg.haddr, cap2_err_pkg::OFS_DEV_CTRL_EXT)) begin
			dev_ctrl_reg <= '0;
			dev_ctrl_reg[cap2_err_pkg::LTR_EN_BIT] <= hwdata[cap2_err_pkg::LTR_EN_BIT];
			dev_ctrl_reg[cap2_err_pkg::BUFFER_FLUSH_FILL_HINT_LO +: 2] <= hwdata[cap2_err_pkg::BUFFER_FLUSH_FILL_HINT_LO +: 2];
		end
	end

	assign latency_tolerance_report_en = dev_ctrl_reg[cap2_err_pkg::LTR_EN_BIT];
	assign buffer_flush_fill_hint = dev_ctrl_reg[cap2_err_pkg::BUFFER_FLUSH_FILL_HINT_LO +: 2];

	// -------------------------------------------------------------
	// link control ext
	// -------------------------------------------------------------
	// sticky part ignores soft reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			link_ctrl_sticky_reg <= {28'h0000000, cap2_err_pkg::TLS_RESET};
		end else if (wr_now && is_addr(addr_reg.haddr, cap2_err_pkg::OFS_LINK_CTRL_EXT)) begin
			link_ctrl_sticky_reg <= hwdata & 32'h00001F9F;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			auto_spd_reg <= 1'b0;
		end else if (soft_reset) begin
			auto_spd_reg <= 1'b0;
		end else if (wr_now && is_addr(addr_reg.haddr, cap2_err_pkg::OFS_LINK_CTRL_EXT)) begin
			auto_spd_reg <= hwdata[cap2_err_pkg::AUTO_SPD_DIS_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cur_deemph_reg <= 1'b0;
		end else if (soft_reset) begin
			cur_deemph_reg <= 1'b0;
		end else begin
			cur_deemph_reg <= cur_deemph_level;
		end
	end

	assign target_link_speed = link_ctrl_sticky_reg[cap2_err_pkg::TLS_LO +: 4];
	assign enter_compliance = link_ctrl_sticky_reg[cap2_err_pkg::ENTER_COMPL_BIT];
	assign autonomous_speed_change_disable = auto_spd_reg;
	assign transmit_margin = link_ctrl_sticky_reg[cap2_err_pkg::MARGIN_LO +: 3];
	assign modified_compliance = link_ctrl_sticky_reg[cap2_err_pkg::MOD_COMPL_BIT];
	assign compliance_skip_ordered_sets = link_ctrl_sticky_reg[cap2_err_pkg::COMPL_SOS_BIT];
	assign compliance_deemphasis = link_ctrl_sticky_reg[cap2_err_pkg::COMPL_DEEMPH_BIT];

	// -------------------------------------------------------------
	// uncorrectable error flags
	// -------------------------------------------------------------
	always_comb begin
		event_vec = '0;
		event_vec[0] = err_events.training_error;
		event_vec[4] = err_events.link_protocol_error;
		event_vec[5] = err_events.surprise_down & DOWNSTREAM;
		event_vec[12] = err_events.poisoned_packet;
		event_vec[13] = err_events.flow_control_error;
		event_vec[14] = err_events.completion_timeout;
		event_vec[15] = err_events.completer_abort;
		event_vec[17] = err_events.receiver_overflow;
		event_vec[18] = err_events.malformed_packet;
		event_vec[19] = err_events.end_to_end_crc_error;
		event_vec[20] = err_events.unsupported_request;
		event_vec[21] = err_events.access_violation;
	end

	// software event injection for test of the flag path
	assign force_vec = (wr_now && is_addr(addr_reg.haddr, cap2_err_pkg::OFS_ERR_EVENT_FORCE))
		? hwdata : 32'h00000000;

	always_comb begin
		uncorr_next = uncorr_reg;
		if (wr_now && is_addr(addr_reg.haddr, cap2_err_pkg::OFS_UNCORR_FLAGS)) begin
			uncorr_next = uncorr_reg & ~hwdata;
		end
		uncorr_next = uncorr_next | event_vec | force_vec;
		uncorr_next = uncorr_next & cap2_err_pkg::UNCORR_IMPL_MASK
			& (DOWNSTREAM ? 32'hFFFFFFFF : ~cap2_err_pkg::SURPRISE_DOWN_MASK);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			uncorr_reg <= '0;
		end else begin
			uncorr_reg <= uncorr_next;
		end
	end

	// -------------------------------------------------------------
	// read mux
	// -------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_DEV_CTRL_EXT)) begin
			rd_word = dev_ctrl_reg;
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_LINK_CAPS_EXT)) begin
			rd_word = '0;
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_LINK_CTRL_EXT)) begin
			rd_word = link_ctrl_sticky_reg;
			rd_word[cap2_err_pkg::AUTO_SPD_DIS_BIT] = auto_spd_reg;
			rd_word[cap2_err_pkg::SEL_DEEMPH_BIT] = DOWNSTREAM;
			rd_word[cap2_err_pkg::CUR_DEEMPH_BIT] = cur_deemph_reg;
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_SLOT_CAPS_EXT)) begin
			rd_word = '0;
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_SLOT_CTRL_EXT)) begin
			rd_word = '0;
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_ERR_CAP_HDR)) begin
			rd_word = {cap2_err_pkg::ERR_NEXT_PTR, cap2_err_pkg::ERR_CAP_VER,
				cap2_err_pkg::ERR_CAP_ID};
		end else if (is_addr(addr_reg.haddr, cap2_err_pkg::OFS_UNCORR_FLAGS)) begin
			rd_word = uncorr_reg;
		end
	end

	assign hrdata = rd_word;
endmodule : cap2_err_regs

// [logic/cap2_err_pkg.sv]
package cap2_err_pkg;
	// -------------------------------------------------------------
	// register byte offsets
	// -------------------------------------------------------------
	localparam logic [11:0] OFS_DEV_CTRL_EXT = 12'h0E8;
	localparam logic [11:0] OFS_LINK_CAPS_EXT = 12'h0EC;
	localparam logic [11:0] OFS_LINK_CTRL_EXT = 12'h0F0;
	localparam logic [11:0] OFS_SLOT_CAPS_EXT = 12'h0F4;
	localparam logic [11:0] OFS_SLOT_CTRL_EXT = 12'h0F8;
	localparam logic [11:0] OFS_ERR_CAP_HDR = 12'h100;
	localparam logic [11:0] OFS_UNCORR_FLAGS = 12'h104;
	localparam logic [11:0] OFS_ERR_EVENT_FORCE = 12'h180;
	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int LTR_EN_BIT = 10;
	localparam int BUFFER_FLUSH_FILL_HINT_LO = 13;
	localparam int TLS_LO = 0;
	localparam int ENTER_COMPL_BIT = 4;
	localparam int AUTO_SPD_DIS_BIT = 5;
	localparam int SEL_DEEMPH_BIT = 6;
	localparam int MARGIN_LO = 7;
	localparam int MOD_COMPL_BIT = 10;
	localparam int COMPL_SOS_BIT = 11;
	localparam int COMPL_DEEMPH_BIT = 12;
	localparam int CUR_DEEMPH_BIT = 16;
	// -------------------------------------------------------------
	// reset and constant values
	// -------------------------------------------------------------
	localparam logic [3:0] TLS_RESET = 4'h2;
	localparam logic [15:0] ERR_CAP_ID = 16'h0001;
	localparam logic [3:0] ERR_CAP_VER = 4'h1;
	localparam logic [11:0] ERR_NEXT_PTR = 12'h140;
	// implemented uncorrectable status bits: 0,4,5,12..15,17..21
	localparam logic [31:0] UNCORR_IMPL_MASK = 32'h003EF031;
	localparam logic [31:0] SURPRISE_DOWN_MASK = 32'h00000020;
	// -------------------------------------------------------------
	// error event carrier
	// -------------------------------------------------------------
	typedef struct packed {
		logic access_violation;
		logic unsupported_request;
		logic end_to_end_crc_error;
		logic malformed_packet;
		logic receiver_overflow;
		logic completer_abort;
		logic completion_timeout;
		logic flow_control_error;
		logic poisoned_packet;
		logic surprise_down;
		logic link_protocol_error;
		logic training_error;
	} err_events_t;

	typedef struct packed {
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] haddr;
	} ahb_addr_t;
endpackage : cap2_err_pkg

// [sim/cap2_err_regs_checker.sv]
`timescale 1ns/100ps
module cap2_err_regs_checker #(
	parameter bit DOWNSTREAM = 1'b0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic latency_tolerance_report_en,
	input wire logic [1:0] buffer_flush_fill_hint,
	input wire logic [3:0] target_link_speed,
	input wire logic [2:0] transmit_margin,
	input wire logic autonomous_speed_change_disable
);
	logic wr_dp;
	logic rd_dp;
	logic [11:0] dp_addr;
	logic acc;
	assign acc = hsel && htrans[1] && hready;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_dp <= 1'b0;
			rd_dp <= 1'b0;
		end else begin
			wr_dp <= acc && hwrite;
			rd_dp <= acc && !hwrite;
		end
	end
	always_ff @(posedge core_clk) begin
		dp_addr <= haddr[11:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_SPEED_AT_RESET: assert property ($fell(reset) |-> target_link_speed == 4'h2)
		else $error("link speed not at reset value");
	AST_LINK_WRITE: assert property (wr_dp && dp_addr == 12'h0F0 |=>
		target_link_speed == $past(hwdata[3:0]) && transmit_margin == $past(hwdata[9:7]))
		else $error("link control write not taken");
	AST_AUTO_WRITE: assert property (wr_dp && dp_addr == 12'h0F0 && !soft_reset |=>
		autonomous_speed_change_disable == $past(hwdata[5])) else $error("speed disable lost");
	AST_DEV_WRITE: assert property (wr_dp && dp_addr == 12'h0E8 && !soft_reset |=>
		{buffer_flush_fill_hint, latency_tolerance_report_en} == $past({hwdata[14:13], hwdata[10]}))
		else $error("device control write not taken");
	AST_SOFT_KEEP: assert property (soft_reset && !wr_dp |=>
		$stable(target_link_speed) && $stable(transmit_margin) && !latency_tolerance_report_en)
		else $error("soft reset wrong on sticky fields");
	AST_ZERO_WORDS: assert property (rd_dp && dp_addr inside {12'h0EC, 12'h0F4, 12'h0F8} |->
		hrdata == 32'h0) else $error("read-only zero word not zero");
	AST_HDR_READ: assert property (rd_dp && dp_addr == 12'h100 |-> hrdata == 32'h14010001)
		else $error("capability header wrong");
	AST_DEV_READ: assert property (rd_dp && dp_addr == 12'h0E8 |-> hrdata ==
		{17'h0, buffer_flush_fill_hint, 2'h0, latency_tolerance_report_en, 10'h0})
		else $error("device control word wrong");
	AST_LINK_READ: assert property (rd_dp && dp_addr == 12'h0F0 |-> hrdata[6] == DOWNSTREAM
		&& hrdata[31:17] == 15'h0 && hrdata[3:0] == target_link_speed) else $error("link word wrong");
	AST_FLAG_RSVD: assert property (rd_dp && dp_addr == 12'h104 |->
		(hrdata & ~32'h003EF031) == 32'h0) else $error("reserved flag bit set");
	COV_LINK_WR: cover property (wr_dp && dp_addr == 12'h0F0);
	COV_SOFT: cover property (soft_reset && !wr_dp);
	COV_FLAGS: cover property (rd_dp && dp_addr == 12'h104 && hrdata != 32'h0);
endmodule : cap2_err_regs_checker
bind cap2_err_regs cap2_err_regs_checker #(.DOWNSTREAM(DOWNSTREAM)) u_chk (.core_clk(core_clk),
	.reset(reset), .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.latency_tolerance_report_en(latency_tolerance_report_en),
	.buffer_flush_fill_hint(buffer_flush_fill_hint), .target_link_speed(target_link_speed),
	.transmit_margin(transmit_margin),
	.autonomous_speed_change_disable(autonomous_speed_change_disable));

// [sim/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
	logic core_clk, reset, soft_reset, hsel, hwrite, hreadyout, hresp, cur_deemph_level;
	logic [31:0] haddr, hwdata, hrdata, x;
	logic [1:0] htrans, hint;
	logic [2:0] hsize;
	logic [3:0] tls;
	logic lte;
	logic [3:0] cmpl;
	cap2_err_pkg::err_events_t err_events;
	int err_total, n_compared;
	logic [11:0] ad [5] = '{12'h0E8, 12'h0EC, 12'h0F4, 12'h0F8, 12'h100};
	logic [31:0] ex [5] = '{32'h6400, 32'h0, 32'h0, 32'h0, 32'h14010001};
	int pos [12] = '{0, 4, 5, 12, 13, 14, 15, 17, 18, 19, 20, 21};
	cap2_err_regs #(.DOWNSTREAM(1'b1)) u_dut (.core_clk(core_clk), .reset(reset),
		.soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .err_events(err_events),
		.cur_deemph_level(cur_deemph_level), .latency_tolerance_report_en(lte),
		.buffer_flush_fill_hint(hint), .target_link_speed(tls), .enter_compliance(cmpl[0]),
		.autonomous_speed_change_disable(), .transmit_margin(), .modified_compliance(cmpl[1]),
		.compliance_skip_ordered_sets(cmpl[2]), .compliance_deemphasis(cmpl[3]));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic end_sim();
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			end_sim();
		end
	endtask : wait_rdy
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		x = hrdata;
		`CHK("resp", 1'b0, hresp)
	endtask : bus
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK($sformatf("reg %0h", a), e, x)
	endtask : rc
	task automatic pulse(input bit por);
		if (por) reset <= 1'b1;
		else soft_reset <= 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		soft_reset <= 1'b0;
		@(posedge core_clk);
	endtask : pulse
	initial begin
		{reset, soft_reset, hsel, hwrite, cur_deemph_level, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		err_events = '0;
		err_total = 0;
		n_compared = 0;
		reset = 1'b1;
		pulse(1'b1);
		rc(12'h104, 32'h0);
		rc(12'h1FC, 32'h0);
		rc(12'h0F0, 32'h42);
		`CHK("cmpl", 4'h0, cmpl)
		for (int i = 0; i < 5; i++) begin
			rc(ad[i], (i == 4) ? ex[4] : 32'h0);
			bus(ad[i], 1'b1, 32'hFFFFFFFF);
			rc(ad[i], ex[i]);
		end
		`CHK("ctl", 3'h7, {hint, lte})
		cur_deemph_level <= 1'b1;
		bus(12'h0F0, 1'b1, 32'hFFFFFFFF);
		rc(12'h0F0, 32'h11FFF);
		`CHK("speed", 4'hF, tls)
		`CHK("cmpl", 4'hF, cmpl)
		cur_deemph_level <= 1'b0;
		pulse(1'b0);
		rc(12'h0F0, 32'h1FDF);
		`CHK("cmpl", 4'hF, cmpl)
		rc(12'h0E8, 32'h0);
		for (int i = 0; i < 12; i++) begin
			err_events <= cap2_err_pkg::err_events_t'(12'h1 << i);
			@(posedge core_clk);
			err_events <= '0;
			rc(12'h104, 32'h1 << pos[i]);
			bus(12'h104, 1'b1, 32'h1 << pos[i]);
			rc(12'h104, 32'h0);
		end
		err_events <= cap2_err_pkg::err_events_t'(12'h1);
		bus(12'h104, 1'b1, 32'h1);
		err_events <= '0;
		rc(12'h104, 32'h1);
		bus(12'h180, 1'b1, 32'hFFFFFFFF);
		rc(12'h180, 32'h0);
		rc(12'h104, 32'h003EF031);
		pulse(1'b0);
		rc(12'h104, 32'h003EF031);
		pulse(1'b1);
		rc(12'h104, 32'h0);
		rc(12'h0F0, 32'h42);
		`CHK("cmpl", 4'h0, cmpl)
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		end_sim();
	end
endmodule : tb_top
